// File: tdf_regs.sv
// Status, soft-control and alarm/warning flag bytes of the diagnostic page.
// Assumes a byte-wide host port decoded upstream; pins arrive asynchronously.
module tdf_regs
  import tdf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [tdf_pkg::ADDR_W-1:0] ADDR,
  input wire logic WR_EN,
  input wire logic [tdf_pkg::DATA_W-1:0] WDATA,
  output logic [tdf_pkg::DATA_W-1:0] RDATA,
  input wire logic TX_OFF_PIN,
  input wire logic LASER_FAULT,
  input wire logic RECEIVE_SIGNAL_LOST,
  input wire logic MEAS_VALID,
  input wire logic [5*16-1:0] MEAS,
  input wire logic [5*16-1:0] HI_ALARM,
  input wire logic [5*16-1:0] LO_ALARM,
  input wire logic [5*16-1:0] HI_WARN,
  input wire logic [5*16-1:0] LO_WARN,
  output logic TX_OFF
);
  import tdf_pkg::*;

  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic soft_off_reg;
  logic tx_off_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [2*NUM_MEAS-1:0] alarm_w;
  logic [2*NUM_MEAS-1:0] warn_w;
  logic [2*NUM_MEAS-1:0] ref_alarm;
  logic [2*NUM_MEAS-1:0] ref_warn;

  // Pins are foreign to CLK; two stages before any use
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
    end else begin
      s1_reg <= {TX_OFF_PIN, LASER_FAULT, RECEIVE_SIGNAL_LOST, MEAS_VALID};
      s2_reg <= s1_reg;
    end
  end
  wire logic hw_off = s2_reg[3];
  wire logic fault_s = s2_reg[2];
  wire logic lost_s = s2_reg[1];
  wire logic valid_s = s2_reg[0];

  // Temperature is the only signed channel
  genvar g;
  generate
    for (g = 0; g < NUM_MEAS; g++) begin : g_ch
      tdf_cmp #(.IS_SIGNED(g == MEAS_TEMP)) u_cmp ( // see RL14
        .CLK(CLK),
        .RST(RST),
        .meas(MEAS[g*16 +: 16]),
        .hi_alarm(HI_ALARM[g*16 +: 16]),
        .lo_alarm(LO_ALARM[g*16 +: 16]),
        .hi_warn(HI_WARN[g*16 +: 16]),
        .lo_warn(LO_WARN[g*16 +: 16]),
        .alarm(alarm_w[2*g +: 2]),
        .warn(warn_w[2*g +: 2])
      );
    end
  endgenerate

  wire logic wr_status = WR_EN && (ADDR == OFS_STATUS);
  wire logic soft_off_next = wr_status ? WDATA[BIT_SOFT_OFF] : soft_off_reg; // see RL2
  wire logic tx_off_next = soft_off_reg | hw_off; // see RL3

  // Low byte: temp, vcc, bias, tx power pairs, high/low per pair
  wire logic [7:0] alarm_lo = {alarm_w[1:0], alarm_w[3:2], alarm_w[5:4], alarm_w[7:6]}; // see RL8
  wire logic [7:0] alarm_hi = {alarm_w[9:8], 6'h00}; // see RL10
  wire logic [7:0] warn_lo = {warn_w[1:0], warn_w[3:2], warn_w[5:4], warn_w[7:6]}; // see RL11
  wire logic [7:0] warn_hi = {warn_w[9:8], 6'h00}; // see RL13
  wire logic [7:0] status_b = {hw_off, soft_off_reg, 3'h0, fault_s,
                               lost_s, ~valid_s}; // see RL1 RL4 RL5 RL6

  // Independent reference for the flag checks, not shared with the comparators
  function automatic logic [1:0] ref_pair(input logic [15:0] m, input logic [15:0] h,
                                          input logic [15:0] l, input bit sg);
    if (sg) begin
      ref_pair = {$signed(m) > $signed(h), $signed(m) < $signed(l)};
    end else begin
      ref_pair = {m > h, m < l};
    end
  endfunction

  generate
    for (g = 0; g < NUM_MEAS; g++) begin : g_ref
      assign ref_alarm[2*g +: 2] = ref_pair(MEAS[g*16 +: 16], HI_ALARM[g*16 +: 16],
                                            LO_ALARM[g*16 +: 16], g == MEAS_TEMP);
      assign ref_warn[2*g +: 2] = ref_pair(MEAS[g*16 +: 16], HI_WARN[g*16 +: 16],
                                           LO_WARN[g*16 +: 16], g == MEAS_TEMP);
    end
  endgenerate

  // Unmapped offsets read zero; reserved bits ignore writes
  always_comb begin
    case (ADDR)
      OFS_STATUS: rdata_next = status_b;
      OFS_ALARM_LO: rdata_next = alarm_lo; // see RL9
      OFS_ALARM_HI: rdata_next = alarm_hi;
      OFS_WARN_LO: rdata_next = warn_lo; // see RL12
      OFS_WARN_HI: rdata_next = warn_hi;
      default: rdata_next = 8'h00; // see RL15
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      soft_off_reg <= SOFT_OFF_RESET;
      tx_off_reg <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      soft_off_reg <= soft_off_next;
      tx_off_reg <= tx_off_next; // see RL7
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA = rdata_reg;
  assign TX_OFF = tx_off_reg;

  // Checks
  sequence s_soft_write;
    wr_status && WDATA[BIT_SOFT_OFF];
  endsequence
  sequence s_off_seen;
    ##2 TX_OFF;
  endsequence
  sequence s_soft_clear;
    wr_status && !WDATA[BIT_SOFT_OFF] && !hw_off;
  endsequence
  // Flag reads only count once the flag stage has left reset
  sequence s_rd_alarm_lo;
    ADDR == OFS_ALARM_LO && !$past(RST);
  endsequence
  sequence s_rd_alarm_hi;
    ADDR == OFS_ALARM_HI && !$past(RST);
  endsequence
  sequence s_rd_warn_lo;
    ADDR == OFS_WARN_LO && !$past(RST);
  endsequence
  sequence s_rd_warn_hi;
    ADDR == OFS_WARN_HI && !$past(RST);
  endsequence

  a_soft_off_acts: assert property (@(posedge CLK) disable iff (RST) // see RL7
    s_soft_write |-> s_off_seen) else $error("soft off did not act in two cycles");
  a_tx_off_or: assert property (@(posedge CLK) disable iff (RST) // see RL3
    !$past(RST) |-> TX_OFF == $past(soft_off_reg | hw_off))
    else $error("transmit off is not the OR");
  a_soft_off_clears: assert property (@(posedge CLK) disable iff (RST) // see RL7
    s_soft_clear ##1 !hw_off |=> !TX_OFF)
    else $error("soft clear did not release transmit off");
  a_soft_bit_hold: assert property (@(posedge CLK) disable iff (RST) // see RL2
    !wr_status |=> $stable(soft_off_reg)) else $error("soft bit changed without write");
  a_status_read: assert property (@(posedge CLK) disable iff (RST) // see RL1
    ADDR == OFS_STATUS |=> RDATA[BIT_HW_OFF] == $past(hw_off)) else $error("bad hw off bit");
  a_ready_low: assert property (@(posedge CLK) disable iff (RST) // see RL6
    ADDR == OFS_STATUS |=> RDATA[BIT_READY_N] == !$past(valid_s)) else $error("bad ready");
  a_fault_bit: assert property (@(posedge CLK) disable iff (RST) // see RL4
    ADDR == OFS_STATUS |=> RDATA[BIT_FAULT] == $past(fault_s)) else $error("bad fault bit");
  a_lost_bit: assert property (@(posedge CLK) disable iff (RST) // see RL5
    ADDR == OFS_STATUS |=> RDATA[BIT_LOST] == $past(lost_s)) else $error("bad lost bit");
  a_rsvd_zero: assert property (@(posedge CLK) disable iff (RST) // see RL15
    (ADDR == OFS_ALARM_HI || ADDR == OFS_WARN_HI) |=> RDATA[5:0] == 6'h00)
    else $error("reserved bits not zero");
  a_temp_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL8
    ($signed(MEAS[15:0]) > $signed(HI_ALARM[15:0])) ##1 ADDR == OFS_ALARM_LO
    |=> RDATA[7]) else $error("temperature high alarm missing");

  // Read data lags the flag stage by one cycle, which lags the inputs by one
  a_temp_hi_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL8
    s_rd_alarm_lo |=> RDATA[7] == $past(ref_alarm[1], 2))
    else $error("temp high alarm bit wrong");
  a_temp_lo_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL8
    s_rd_alarm_lo |=> RDATA[6] == $past(ref_alarm[0], 2))
    else $error("temp low alarm bit wrong");
  a_vcc_hi_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL8
    s_rd_alarm_lo |=> RDATA[5] == $past(ref_alarm[3], 2))
    else $error("supply high alarm bit wrong");
  a_vcc_lo_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL8
    s_rd_alarm_lo |=> RDATA[4] == $past(ref_alarm[2], 2))
    else $error("supply low alarm bit wrong");
  a_bias_hi_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL9
    s_rd_alarm_lo |=> RDATA[3] == $past(ref_alarm[5], 2))
    else $error("bias high alarm bit wrong");
  a_bias_lo_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL9
    s_rd_alarm_lo |=> RDATA[2] == $past(ref_alarm[4], 2))
    else $error("bias low alarm bit wrong");
  a_txp_hi_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL9
    s_rd_alarm_lo |=> RDATA[1] == $past(ref_alarm[7], 2))
    else $error("tx power high alarm bit wrong");
  a_txp_lo_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL9
    s_rd_alarm_lo |=> RDATA[0] == $past(ref_alarm[6], 2))
    else $error("tx power low alarm bit wrong");
  a_rxp_hi_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL10
    s_rd_alarm_hi |=> RDATA[7] == $past(ref_alarm[9], 2))
    else $error("rx power high alarm bit wrong");
  a_rxp_lo_alarm: assert property (@(posedge CLK) disable iff (RST) // see RL10
    s_rd_alarm_hi |=> RDATA[6] == $past(ref_alarm[8], 2))
    else $error("rx power low alarm bit wrong");
  a_temp_hi_warn: assert property (@(posedge CLK) disable iff (RST) // see RL11
    s_rd_warn_lo |=> RDATA[7] == $past(ref_warn[1], 2))
    else $error("temp high warning bit wrong");
  a_temp_lo_warn: assert property (@(posedge CLK) disable iff (RST) // see RL11
    s_rd_warn_lo |=> RDATA[6] == $past(ref_warn[0], 2))
    else $error("temp low warning bit wrong");
  a_vcc_hi_warn: assert property (@(posedge CLK) disable iff (RST) // see RL11
    s_rd_warn_lo |=> RDATA[5] == $past(ref_warn[3], 2))
    else $error("supply high warning bit wrong");
  a_vcc_lo_warn: assert property (@(posedge CLK) disable iff (RST) // see RL11
    s_rd_warn_lo |=> RDATA[4] == $past(ref_warn[2], 2))
    else $error("supply low warning bit wrong");
  a_bias_hi_warn: assert property (@(posedge CLK) disable iff (RST) // see RL12
    s_rd_warn_lo |=> RDATA[3] == $past(ref_warn[5], 2))
    else $error("bias high warning bit wrong");
  a_bias_lo_warn: assert property (@(posedge CLK) disable iff (RST) // see RL12
    s_rd_warn_lo |=> RDATA[2] == $past(ref_warn[4], 2))
    else $error("bias low warning bit wrong");
  a_txp_hi_warn: assert property (@(posedge CLK) disable iff (RST) // see RL12
    s_rd_warn_lo |=> RDATA[1] == $past(ref_warn[7], 2))
    else $error("tx power high warning bit wrong");
  a_txp_lo_warn: assert property (@(posedge CLK) disable iff (RST) // see RL12
    s_rd_warn_lo |=> RDATA[0] == $past(ref_warn[6], 2))
    else $error("tx power low warning bit wrong");
  a_rxp_hi_warn: assert property (@(posedge CLK) disable iff (RST) // see RL13
    s_rd_warn_hi |=> RDATA[7] == $past(ref_warn[9], 2))
    else $error("rx power high warning bit wrong");
  a_rxp_lo_warn: assert property (@(posedge CLK) disable iff (RST) // see RL13
    s_rd_warn_hi |=> RDATA[6] == $past(ref_warn[8], 2))
    else $error("rx power low warning bit wrong");
endmodule

// File: tdf_pkg.sv
// Constants for the diagnostic status and flag register bank.
// Assumes one 100 MHz clock and a host register port of byte width.
// Function
// RL1 - Bit 7 of the status byte reads the level of the hardware transmit-off input.
// RL2 - Bit 6 of the status byte is a host-writable, readable soft transmit-off bit.
// RL3 - The transmitter is off when the soft bit or the hardware input is set.
// RL4 - Bit 2 of the status byte reads the laser-fault output state.
// RL5 - Bit 1 of the status byte reads the receive-signal-lost output state.
// RL6 - Bit 0 of the status byte is an active-low ready flag, 0 once data is valid.
// RL7 - Soft commands take effect and show in status within 100 ms.
// RL8 - Alarm byte 112 bits 7/6 flag temperature high/low, bits 5/4 supply high/low.
// RL9 - Alarm byte 112 bits 3/2 flag bias high/low, bits 1/0 transmit power high/low.
// RL10 - Alarm byte 113 bits 7/6 flag receive power high/low; bits 5..0 are reserved.
// RL11 - Warning byte 116 bits 7/6 flag temperature, bits 5/4 supply voltage.
// RL12 - Warning byte 116 bits 3/2 flag bias, bits 1/0 transmit power.
// RL13 - Warning byte 117 bits 7/6 flag receive power; bits 5..0 are reserved.
// RL14 - Temperature and its thresholds are signed 16-bit values in 1/256 degree steps.
// RL15 - Reserved bits read zero and only the soft transmit-off bit is writable.
// RL16 - Every flag is recomputed from the latest measurement and clears by itself.
package tdf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h6E;
  localparam logic [7:0] OFS_ALARM_LO = 8'h70;
  localparam logic [7:0] OFS_ALARM_HI = 8'h71;
  localparam logic [7:0] OFS_WARN_LO = 8'h74;
  localparam logic [7:0] OFS_WARN_HI = 8'h75;
  localparam int BIT_HW_OFF = 7;
  localparam int BIT_SOFT_OFF = 6;
  localparam int BIT_FAULT = 2;
  localparam int BIT_LOST = 1;
  localparam int BIT_READY_N = 0;
  localparam logic SOFT_OFF_RESET = 1'b0;
  localparam int NUM_MEAS = 5;
  localparam int CLK_MHZ = 100;
  localparam int SOFT_RESP_MS = 100;
  localparam int SOFT_RESP_CYC = SOFT_RESP_MS * 1000 * CLK_MHZ;
  localparam int SOFT_LAT_CYC = 2;
  typedef enum {MEAS_TEMP, MEAS_VCC, MEAS_BIAS, MEAS_TXP, MEAS_RXP} tdf_meas_t;
endpackage

// File: tdf_cmp.sv
// Threshold comparator for one measurement channel, registered flags.
// Assumes thresholds and measurement are stable in the CLK domain.
module tdf_cmp #(
  parameter bit IS_SIGNED = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] meas,
  input wire logic [15:0] hi_alarm,
  input wire logic [15:0] lo_alarm,
  input wire logic [15:0] hi_warn,
  input wire logic [15:0] lo_warn,
  output logic [1:0] alarm,
  output logic [1:0] warn
);
  function automatic logic above(input logic [15:0] a, input logic [15:0] b, input bit sg);
    above = sg ? ($signed(a) > $signed(b)) : (a > b);
  endfunction
  wire logic [1:0] alarm_next = {above(meas, hi_alarm, IS_SIGNED),
                                 above(lo_alarm, meas, IS_SIGNED)};
  wire logic [1:0] warn_next = {above(meas, hi_warn, IS_SIGNED),
                                above(lo_warn, meas, IS_SIGNED)};
  // Recomputed each cycle, so flags clear when the condition ends
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      alarm <= 2'h0;
      warn <= 2'h0;
    end else begin
      alarm <= alarm_next; // see RL16
      warn <= warn_next;
    end
  end
endmodule

// File: tdf_host.sv
// Host model: drives the byte register port of the flag bank.
// Assumes RDATA is registered one cycle after the address.
module tdf_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr_en,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wr_en = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d; // Stale data must not mimic the write
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    d = rdata;
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the status and flag bytes.
// Assumes the host model and the fixed read and pin latencies.
module tb
  import tdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr_en, tx_off;
  logic tx_off_pin = 1'b0, fault = 1'b0, lost = 1'b0, valid = 1'b1;
  logic [7:0] addr, wdata, rdata, v;
  logic [79:0] meas = {5{16'h0250}};
  logic [79:0] hia = {5{16'h0400}}, loa = {5{16'h0100}}, hiw = {5{16'h0300}}, low = {5{16'h0200}};
  logic [15:0] vals [5] = '{16'h0500, 16'h0350, 16'h0150, 16'h0050, 16'hFF00};
  int n_fail = 0, checked = 0;
  initial forever #5 clk = ~clk;
  tdf_host host (.clk(clk), .addr(addr), .wr_en(wr_en), .wdata(wdata), .rdata(rdata));
  tdf_regs dut (.CLK(clk), .RST(rst), .ADDR(addr), .WR_EN(wr_en), .WDATA(wdata), .RDATA(rdata),
    .TX_OFF_PIN(tx_off_pin), .LASER_FAULT(fault), .RECEIVE_SIGNAL_LOST(lost), .MEAS_VALID(valid),
    .MEAS(meas), .HI_ALARM(hia), .LO_ALARM(loa), .HI_WARN(hiw), .LO_WARN(low), .TX_OFF(tx_off));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Temperature alone is signed; a negative value must read low
  function automatic logic [1:0] pair(int c, logic [15:0] m, logic [15:0] h, logic [15:0] l);
    if (c == 0) return {$signed(m) > $signed(h), $signed(m) < $signed(l)};
    return {m > h, m < l};
  endfunction
  initial begin
    logic [1:0] a, w;
    logic [79:0] m;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {tx_off_pin, fault, lost, valid} <= i[3:0];
      repeat (3) @(posedge clk);
      host.rd(OFS_STATUS, v);
      check(v, {i[3], 4'h0, i[2:1], ~i[0]});
      check({7'h0, tx_off}, {7'h0, i[3]});
    end
    $display("status pins test done");
    @(posedge clk);
    {tx_off_pin, fault, lost, valid} <= 4'h1;
    repeat (3) @(posedge clk);
    host.wr(OFS_STATUS, 8'hFF);
    host.rd(OFS_STATUS, v);
    check(v, 8'h40);
    check({7'h0, tx_off}, 8'h01);
    host.wr(OFS_STATUS, 8'h00);
    host.rd(OFS_STATUS, v);
    check(v, 8'h00);
    check({7'h0, tx_off}, 8'h00);
    host.wr(OFS_ALARM_LO, 8'hFF);
    host.rd(OFS_ALARM_LO, v);
    check(v, 8'h00);
    host.rd(8'h6F, v);
    check(v, 8'h00);
    host.wr(OFS_STATUS, 8'h40);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({7'h0, tx_off}, 8'h01);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    host.rd(OFS_STATUS, v);
    check(v, 8'h00);
    $display("soft control test done");
    for (int c = 0; c < 5; c++) begin
      for (int k = 0; k < 5; k++) begin
        m = {5{16'h0250}};
        m[c*16 +: 16] = vals[k];
        @(posedge clk);
        meas <= m;
        repeat (3) @(posedge clk);
        a = pair(c, vals[k], 16'h0400, 16'h0100);
        w = pair(c, vals[k], 16'h0300, 16'h0200);
        host.rd(OFS_ALARM_LO, v);
        check(v, (c < 4) ? {a, 6'h0} >> (2 * c) : 8'h00);
        host.rd(OFS_ALARM_HI, v);
        check(v, (c == 4) ? {a, 6'h0} : 8'h00);
        host.rd(OFS_WARN_LO, v);
        check(v, (c < 4) ? {w, 6'h0} >> (2 * c) : 8'h00);
        host.rd(OFS_WARN_HI, v);
        check(v, (c == 4) ? {w, 6'h0} : 8'h00);
      end
    end
    $display("flag threshold test done");
    complete_run();
  end
  initial begin
    #100us;
    n_fail++;
    complete_run();
  end
endmodule
